// ---- hw/srd_pkg.sv ----
// Shared constants of the stripe reader output stage.
// Assumes a 200 MHz core clock; all times are converted to cycles here.
package srd_pkg;
    localparam int CLK_MHZ = 200;
    // Flux reversals sensed before card-detect is asserted
    localparam logic [3:0] FLUX_DETECT_COUNT = 4'he;
    // Card-detect release after the last strobe
    localparam int CARD_GONE_MS = 150;
    localparam int CARD_GONE_CYCLES = CARD_GONE_MS * 1000 * CLK_MHZ;
    localparam int IDLE_CNT_W = 25;
    // Strobe shape: data setup, low time, data hold
    localparam int STB_SETUP_NS = 500;
    localparam int STB_LOW_NS = 1000;
    localparam int STB_HOLD_NS = 500;
    localparam logic [7:0] STB_SETUP_CYC = 8'((STB_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STB_LOW_CYC = 8'((STB_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STB_HOLD_CYC = 8'((STB_HOLD_NS * CLK_MHZ + 999) / 1000);
    // Reset values of the active-low reader lines
    localparam logic LINE_IDLE = 1'b1;
endpackage

// ---- hw/srd_strobe_gen.sv ----
// Strobe pulse generator and its carrier interface.
// Assumes an active-high reset from the top module, asserted asynchronously.
`timescale 1ns/1ps

interface srd_stb_if;
    logic start;
    logic bitOne;
    logic busy;
    logic strobeN;
    logic dataN;
    modport gen (input start, input bitOne, output busy, output strobeN, output dataN);
    modport ctl (output start, output bitOne, input busy, input strobeN, input dataN);
endinterface

module srd_strobe_gen
    import srd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    srd_stb_if.gen stb
);
    typedef enum logic [1:0] {SG_IDLE, SG_SETUP, SG_LOW, SG_HOLD} srd_sg_state_t;
    typedef struct packed {
        srd_sg_state_t state;
        logic [7:0] cnt;
        logic dataN;
        logic strobeN;
    } srd_sg_t;

    srd_sg_t s_r;
    srd_sg_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            SG_IDLE: begin
                if (stb.start) begin
                    s_nxt.dataN = ~stb.bitOne; // R7
                    s_nxt.cnt = STB_SETUP_CYC;
                    s_nxt.state = SG_SETUP;
                end
            end
            SG_SETUP: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.strobeN = 1'b0; // R5
                    s_nxt.cnt = STB_LOW_CYC;
                    s_nxt.state = SG_LOW;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            SG_LOW: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.strobeN = LINE_IDLE;
                    s_nxt.cnt = STB_HOLD_CYC;
                    s_nxt.state = SG_HOLD;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            SG_HOLD: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.dataN = LINE_IDLE; // R1
                    s_nxt.state = SG_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            default: begin
                s_nxt.state = SG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{state: SG_IDLE, cnt: 8'h00, dataN: LINE_IDLE, strobeN: LINE_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign stb.busy = (s_r.state != SG_IDLE);
    assign stb.strobeN = s_r.strobeN;
    assign stb.dataN = s_r.dataN;
endmodule

// ---- hw/srd_reader.sv ----
// Output stage of a stripe reader: card-detect, strobe and data lines.
// Assumes fluxIn is an asynchronous pin toggling per head flux reversal,
// and recovered bits come in card order from same-clock decoder logic.
`timescale 1ns/1ps

// Behaviour
// [R1] Lines high while idle, active low
// [R2] Card-detect falls before strobe or data
// [R3] Card-detect after fourteen flux reversals
// [R4] No strobes before card-detect asserts
// [R5] One strobe per recovered bit
// [R6] Host samples data on strobe fall
// [R7] Data low at strobe means one
// [R8] Strobes stop when card leaves head
// [R9] Card-detect releases 150 ms after strobes
// [R10] Host checks parity and LRC
// [R11] Host forwards data only without errors
// [R12] Characters sent least significant bit first
// [R13] Host may store character per byte
// [R14] Host may pack bits contiguously
// [R15] Host may count strobes instead
// [R16] Tracks two, three: four bits plus parity
// [R17] Track one: six bits plus parity
// [R18] Check character is XOR, odd parity
// [R19] Host synchronises the three lines
module srd_reader
    import srd_pkg::*;
#(
    parameter int unsigned CARD_GONE_CYC = CARD_GONE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic fluxIn,
    input wire logic bitValid,
    input wire logic bitValue,
    output logic bitReady,
    output logic cardPresentN,
    output logic strobeN,
    output logic dataN
);
    typedef struct packed {
        logic fluxSync1;
        logic fluxSync2;
        logic fluxPrev;
        logic [3:0] fluxCount;
        logic cardOn;
        logic [IDLE_CNT_W-1:0] idleCnt;
        logic bitReady;
        logic cardPresentN;
    } srd_top_t;

    logic [1:0] rstSync_r;
    logic rst;
    srd_top_t s_r;
    srd_top_t s_nxt;
    logic fluxEdge;
    logic idleDone;
    logic take;

    srd_stb_if stb();

    srd_strobe_gen u_gen (
        .clk(core_clk),
        .rst(rst),
        .stb(stb)
    );

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rst = ~rstSync_r[1];

    assign fluxEdge = s_r.fluxSync2 ^ s_r.fluxPrev;
    assign idleDone = (32'(s_r.idleCnt) >= CARD_GONE_CYC - 1);
    // Bits only accepted while card-detect is low
    assign take = bitValid && s_r.bitReady && s_r.cardOn; // R4
    assign stb.start = take; // R5
    assign stb.bitOne = bitValue; // R12

    always_comb begin
        s_nxt = s_r;
        s_nxt.fluxSync1 = fluxIn;
        s_nxt.fluxSync2 = s_r.fluxSync1;
        s_nxt.fluxPrev = s_r.fluxSync2;
        if (!s_r.cardOn) begin
            if (fluxEdge) begin
                s_nxt.idleCnt = '0;
                if (s_r.fluxCount == FLUX_DETECT_COUNT - 4'h1) begin
                    s_nxt.cardOn = 1'b1; // R3
                    s_nxt.fluxCount = 4'h0;
                end else begin
                    s_nxt.fluxCount = s_r.fluxCount + 4'h1;
                end
            end else if (s_r.fluxCount != 4'h0) begin
                // Stray reversals are forgotten after the same quiet time
                if (idleDone) begin
                    s_nxt.fluxCount = 4'h0;
                    s_nxt.idleCnt = '0;
                end else begin
                    s_nxt.idleCnt = s_r.idleCnt + 1'b1;
                end
            end
        end else begin
            if (take || stb.busy) begin
                s_nxt.idleCnt = '0; // R8
            end else if (idleDone) begin
                s_nxt.cardOn = 1'b0; // R9
                s_nxt.idleCnt = '0;
            end else begin
                s_nxt.idleCnt = s_r.idleCnt + 1'b1;
            end
        end
        s_nxt.bitReady = s_nxt.cardOn && !stb.busy && !take;
        // Card-detect leads; strobes need a full setup time after it
        s_nxt.cardPresentN = ~s_nxt.cardOn; // R2
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '{fluxSync1: 1'b0, fluxSync2: 1'b0, fluxPrev: 1'b0,
                     fluxCount: 4'h0, cardOn: 1'b0, idleCnt: '0,
                     bitReady: 1'b0, cardPresentN: LINE_IDLE}; // R1
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bitReady = s_r.bitReady;
    assign cardPresentN = s_r.cardPresentN;
    assign strobeN = stb.strobeN;
    assign dataN = stb.dataN;
endmodule

// ---- verif/srd_reader_properties.sv ----
// Checker of the reader output lines.
// Assumes binding into srd_reader.
`timescale 1ns/1ps
module srd_reader_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic fluxIn,
    input wire logic bitValid,
    input wire logic bitValue,
    input wire logic bitReady,
    input wire logic cardPresentN,
    input wire logic strobeN,
    input wire logic dataN
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_take; bitValid && bitReady; endsequence
    sequence s_pulse; ##100 strobeN ##1 !strobeN ##199 !strobeN ##1 strobeN; endsequence
    a_idle_lines: assert property (cardPresentN && $past(cardPresentN) |->
        strobeN && dataN && !bitReady) else $error("line active without card");
    a_detect_first: assert property ($fell(cardPresentN) |-> strobeN && dataN)
        else $error("card detect not first");
    a_take_data: assert property (s_take |=> dataN == !$past(bitValue))
        else $error("data level wrong");
    a_strobe_shape: assert property (s_take |-> s_pulse)
        else $error("strobe pulse wrong");
    a_strobe_cause: assert property ($fell(strobeN) |->
        $past(bitValid, 101) && $past(bitReady, 101)) else $error("strobe without bit");
    a_data_hold: assert property (!strobeN |-> $stable(dataN))
        else $error("data moved in strobe");
    a_ready_gap: assert property (s_take |=> !bitReady [*8])
        else $error("second bit too soon");
    // Cycles since a bit was taken, for the late release check
    logic [8:0] relCnt_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            relCnt_r <= 9'h000;
        end else if (bitValid && bitReady) begin
            relCnt_r <= 9'h001;
        end else if (relCnt_r != 9'h000 && relCnt_r != 9'h191) begin
            relCnt_r <= relCnt_r + 9'h001;
        end else begin
            relCnt_r <= 9'h000;
        end
    end
    a_data_release: assert property (relCnt_r == 9'h191 |-> dataN && strobeN)
        else $error("data not released");
endmodule
bind srd_reader srd_reader_properties i_props (.core_clk(core_clk), .rstn(rstn), .fluxIn(fluxIn),
    .bitValid(bitValid), .bitValue(bitValue), .bitReady(bitReady),
    .cardPresentN(cardPresentN), .strobeN(strobeN), .dataN(dataN));

// ---- verif/srd_host_model.sv ----
// Host that collects reader bits.
// Assumes the reader lines come straight from the design.
`timescale 1ns/1ps
module srd_host_model (
    input wire logic strobeN,
    input wire logic dataN,
    input wire logic cardPresentN,
    output logic [15:0] bits,
    output logic [4:0] count,
    output logic checkOk
);
    // Track two and three characters: four data bits and odd parity
    localparam int CHAR_W = 5;
    localparam int CHARS = 3;
    logic started = 1'b0;
    logic [7:0] chars [CHARS];
    logic [3:0] lrc;
    logic par;
    int n;
    initial bits = '0;
    initial count = '0;
    initial checkOk = 1'b0;
    // Parity and check character once card-detect releases
    always @(posedge cardPresentN) begin
        lrc = 4'h0;
        checkOk = (count == 5'(CHARS * CHAR_W));
        for (n = 0; n < CHARS; n++) begin
            chars[n] = 8'(bits[n * CHAR_W +: CHAR_W]);
            par = ^chars[n];
            checkOk = checkOk && par;
            lrc = lrc ^ chars[n][3:0];
        end
        checkOk = checkOk && (lrc == 4'h0);
    end
    always @(negedge strobeN) begin
        if (!cardPresentN && (started || !dataN)) begin
            started = 1'b1;
            bits[count[3:0]] = !dataN;
            count = count + 5'h1;
        end
    end
endmodule

// ---- verif/srd_reader_test.sv ----
// Self-checking bench of the reader output stage.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
module srd_reader_test;
    localparam int unsigned GONE = 2000;
    logic core_clk, rstn, fluxIn, bitValid, bitValue;
    logic bitReady, cardPresentN, strobeN, dataN;
    logic [15:0] hostBits;
    logic [4:0] hostCount;
    logic hostOk;
    logic [1:0] mon;
    logic [1:0] rows [16] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2,
        2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
    int fails = 0;
    int totalChecks = 0;
    int i, k;
    assign mon = {bitReady, cardPresentN};
    srd_reader #(.CARD_GONE_CYC(GONE)) i_dut (.core_clk(core_clk), .rstn(rstn),
        .fluxIn(fluxIn), .bitValid(bitValid), .bitValue(bitValue), .bitReady(bitReady),
        .cardPresentN(cardPresentN), .strobeN(strobeN), .dataN(dataN));
    srd_host_model i_host (.strobeN(strobeN), .dataN(dataN), .cardPresentN(cardPresentN),
        .bits(hostBits), .count(hostCount), .checkOk(hostOk));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_on(input string nm, input int sel, input logic lvl, input int lim);
        for (i = 0; i < lim && mon[sel] !== lvl; i++) tick(1);
        if (mon[sel] !== lvl) begin
            chk(nm, 16'(lvl), 16'(mon[sel]));
            complete_run();
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        rstn = 1'b0;
        fluxIn = 1'b0;
        bitValid = 1'b0;
        bitValue = 1'b0;
        tick(6);
        rstn = 1'b1;
        tick(3);
        chk("idle lines", 16'he, 16'({cardPresentN, strobeN, dataN, bitReady}));
        bitValid = 1'b1;
        repeat (13) begin
            #24 fluxIn = ~fluxIn;
        end
        tick(10);
        chk("early lines", 16'he, 16'({cardPresentN, strobeN, dataN, bitReady}));
        fluxIn = ~fluxIn;
        wait_on("card detect", 0, 1'b0, 10);
        for (k = 0; k < 16; k++) begin
            bitValue = rows[k][1];
            wait_on("bit ready", 1, 1'b1, 500);
            tick(1);
            chk("data line", 16'(rows[k][0]), 16'(dataN));
        end
        bitValid = 1'b0;
        tick(420);
        chk("host bits", 16'h13eb, hostBits);
        chk("host count", 16'h000f, 16'(hostCount));
        tick(GONE - 600);
        chk("card held", 16'h0, 16'(cardPresentN));
        wait_on("card gone", 0, 1'b1, 800);
        chk("ready gone", 16'h0, 16'(bitReady));
        chk("host check", 16'h1, 16'(hostOk));
        // Partial reversal count is forgotten after the quiet time
        repeat (7) #24 fluxIn = ~fluxIn;
        tick(GONE + 20);
        repeat (7) #24 fluxIn = ~fluxIn;
        tick(10);
        chk("forgotten flux", 16'he, 16'({cardPresentN, strobeN, dataN, bitReady}));
        repeat (7) #24 fluxIn = ~fluxIn;
        wait_on("card again", 0, 1'b0, 10);
        bitValue = 1'b1;
        bitValid = 1'b1;
        tick(150);
        chk("strobe mid", 16'h0, 16'({strobeN, dataN}));
        // Reset in the middle of a strobe
        rstn = 1'b0;
        bitValid = 1'b0;
        tick(3);
        chk("reset lines", 16'he, 16'({cardPresentN, strobeN, dataN, bitReady}));
        rstn = 1'b1;
        tick(3);
        chk("restart lines", 16'he, 16'({cardPresentN, strobeN, dataN, bitReady}));
        complete_run();
    end
endmodule
